// File: core/mts_hexdig.sv
// ASCII digit character to nibble converter
`timescale 1ns/100ps
`default_nettype none
module mts_hexdig (
  input wire logic [7:0] char_in,
  output logic [3:0] nibble,
  output logic is_hex,
  output logic is_dec
);
  always_comb begin
    nibble = 4'h0;
    is_hex = 1'b0;
    is_dec = 1'b0;
    if (char_in >= 8'h30 && char_in <= 8'h39) begin
      nibble = 4'(char_in - 8'h30);
      is_hex = 1'b1;
      is_dec = 1'b1;
    end else if (char_in >= 8'h41 && char_in <= 8'h46) begin
      nibble = 4'(char_in - 8'h37);
      is_hex = 1'b1;
    end
  end
endmodule : mts_hexdig
`default_nettype wire

// File: core/mts_pkg.sv
// Constants, codes and state types for the memory table and touch switch command block
package mts_pkg;
  localparam logic [7:0] ESC_CHAR = 8'h1B;
  localparam logic [7:0] CR_CHAR = 8'h0D;
  localparam logic [7:0] CODE_STR_WR = 8'h42;
  localparam logic [7:0] CODE_NUM4_WR = 8'h43;
  localparam logic [7:0] CODE_NUM8_WR = 8'h44;
  localparam logic [7:0] CODE_COPY = 8'h2F;
  localparam logic [7:0] TYPE_STR = 8'h30;
  localparam logic [7:0] TYPE_NUM = 8'h31;
  localparam logic [7:0] CODE_NOTE4 = 8'h45;
  localparam logic [7:0] CODE_NOTE8 = 8'h46;
  localparam logic [7:0] CODE_SW_NUM = 8'h48;
  localparam logic [7:0] CODE_SW_BIT = 8'h49;
  localparam logic [7:0] MARK_MIN = 8'h80;
  localparam logic [7:0] STR_LEN_MIN = 8'h01;
  localparam logic [7:0] STR_LEN_MAX = 8'h20;
  localparam logic [11:0] ADDR_MAX = 12'h07F;
  localparam int STR_ENTRIES = 128;
  localparam int STR_BYTES = 32;
  localparam int NUM_ENTRIES = 128;
  localparam int SW_ROWS = 8;
  localparam int SW_COLS = 8;
  localparam int NUM_SW = 64;
  localparam logic [4:0] NIB_NOTE4 = 5'h07;
  localparam logic [4:0] NIB_NOTE8 = 5'h0B;
  localparam logic [4:0] NIB_SW_NUM = 5'h08;
  localparam logic [4:0] NIB_SW_BIT = 5'h10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int GAP_TIME_MS = 5000;
  localparam int LIGHT_TIME_MS = 200;
  // Divide first: the plain product would overflow a 32-bit int
  localparam logic [12:0] GAP_TICKS = 13'(GAP_TIME_MS * (1000000 / TICK_TIME_NS));
  localparam logic [7:0] LIGHT_TICKS = 8'(LIGHT_TIME_MS * (1000000 / TICK_TIME_NS));

  typedef enum logic [10:0] {
    ST_IDLE = 11'h001, ST_CODE = 11'h002, ST_SLEN = 11'h004, ST_SADDR = 11'h008,
    ST_SDATA = 11'h010, ST_NADDR = 11'h020, ST_NDATA = 11'h040, ST_CTYPE = 11'h080,
    ST_CSRC = 11'h100, ST_CDST = 11'h200, ST_COPY = 11'h400
  } mts_state_enum_type;

  typedef struct packed {
    logic [6:0] addr;
    logic [31:0] value;
    logic wide;
  } mts_numset_type;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } mts_tick_type;

  typedef struct packed {
    mts_state_enum_type st;
    logic [3:0] dig;
    logic [31:0] acc;
    logic [5:0] len;
    logic [6:0] units;
    logic [4:0] pos;
    logic [6:0] sel_addr;
    logic [6:0] src;
    logic wide;
    logic ctype;
    logic [12:0] gap;
    logic err;
    logic [63:0] sw_s1;
    logic [63:0] sw_s2;
    logic [63:0] sw_prev;
    logic [63:0] light;
    logic [7:0] light_cnt;
    logic bit_mode;
    logic np_valid;
    logic np_done;
    logic np_free;
    mts_numset_type np;
    logic sw_pend;
    logic [7:0] sw_code;
    logic [63:0] sw_val;
    logic [4:0] sw_nib;
    logic tx_busy;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [7:0] tx_code;
    logic [63:0] tx_val;
    logic [4:0] tx_nib;
    logic [4:0] tx_pos;
  } mts_state_type;
endpackage : mts_pkg

// File: core/mts_tick.sv
// Divider giving a one-cycle enable pulse every CYCLES clocks
`timescale 1ns/100ps
`default_nettype none
module mts_tick import mts_pkg::*; #(
  parameter int CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic nrst,
  output logic tick
);
  mts_tick_type r, next_r;

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.cnt >= 32'(CYCLES - 1)) begin
      next_r.cnt = 32'h0000_0000;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;
endmodule : mts_tick
`default_nettype wire

// File: core/mts_top.sv
// Host command decoder for memory tables and touch switch notification and lighting
`timescale 1ns/100ps
`default_nettype none
module mts_top import mts_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic TX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic [63:0] SW_PRESS,
  input wire logic BIT_MODE,
  input wire logic NUM_SET_VALID,
  input wire mts_numset_type NUM_SET,
  output logic NUM_SET_READY,
  output logic [63:0] SW_LIGHT,
  output logic TIMEOUT_ERR
);
  mts_state_type r, next_r;
  logic [7:0] str_mem [STR_ENTRIES*STR_BYTES];
  logic [5:0] len_mem [STR_ENTRIES];
  logic [31:0] num_mem [NUM_ENTRIES];

  logic tick;
  logic [3:0] nib;
  logic is_hex;
  logic is_dec;
  logic str_we;
  logic [11:0] str_widx;
  logic [7:0] str_wdata;
  logic len_we;
  logic [6:0] len_widx;
  logic [5:0] len_wdata;
  logic num_we;
  logic [6:0] num_widx;
  logic [31:0] num_wdata;
  logic host_num_we;
  logic [63:0] eff;
  logic [7:0] hex_val;
  logic [11:0] hex_acc;
  logic [11:0] dec_acc;
  logic [6:0] unit_sum;
  logic [31:0] num_val;
  logic [63:0] held;
  logic [5:0] press_idx;

  mts_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clock(CLOCK),
    .nrst(NRST),
    .tick(tick)
  );

  mts_hexdig u_hexdig (
    .char_in(RX_DATA),
    .nibble(nib),
    .is_hex(is_hex),
    .is_dec(is_dec)
  );

  function automatic logic [7:0] to_ascii(input logic [3:0] n);
    to_ascii = (n < 4'hA) ? 8'(8'h30 + {4'h0, n}) : 8'(8'h37 + {4'h0, n});
  endfunction : to_ascii

  always_comb begin
    next_r = r;
    str_we = 1'b0;
    str_widx = 12'h000;
    str_wdata = 8'h00;
    len_we = 1'b0;
    len_widx = 7'h00;
    len_wdata = 6'h00;
    host_num_we = 1'b0;
    num_we = 1'b0;
    num_widx = 7'h00;
    num_wdata = 32'h0000_0000;
    press_idx = 6'h00;
    hex_val = {r.acc[3:0], nib};
    hex_acc = {r.acc[7:0], nib};
    dec_acc = 12'(r.acc[11:0] * 12'h00A + {8'h00, nib});
    num_val = {r.acc[27:0], nib};
    unit_sum = r.units + ((RX_DATA >= MARK_MIN) ? 7'h02 : 7'h01);

    // Switch inputs settle through two flops before anyone looks
    next_r.sw_s1 = SW_PRESS;
    next_r.sw_s2 = r.sw_s1;

    // Matrix ghosting: rows sharing a column merge their columns
    eff = r.sw_s2;
    for (int a = 0; a < SW_ROWS; a++) begin
      for (int b = 0; b < SW_ROWS; b++) begin
        if (a != b && |(r.sw_s2[a*SW_COLS +: SW_COLS] & r.sw_s2[b*SW_COLS +: SW_COLS])) begin
          eff[a*SW_COLS +: SW_COLS] = eff[a*SW_COLS +: SW_COLS] | r.sw_s2[b*SW_COLS +: SW_COLS];
        end
      end
    end

    case (r.st)
      ST_IDLE: begin
        if (RX_VALID && RX_DATA == ESC_CHAR) begin
          next_r.st = ST_CODE;
          next_r.err = 1'b0;
        end
      end
      ST_CODE: begin
        if (RX_VALID) begin
          next_r.dig = 4'h0;
          next_r.acc = 32'h0000_0000;
          case (RX_DATA)
            CODE_STR_WR: next_r.st = ST_SLEN;
            CODE_NUM4_WR: begin
              next_r.st = ST_NADDR;
              next_r.wide = 1'b0;
            end
            CODE_NUM8_WR: begin
              next_r.st = ST_NADDR;
              next_r.wide = 1'b1;
            end
            CODE_COPY: next_r.st = ST_CTYPE;
            default: next_r.st = ST_IDLE;
          endcase
        end
      end
      ST_SLEN: begin
        if (RX_VALID) begin
          next_r.acc = {r.acc[27:0], nib};
          next_r.dig = r.dig + 4'h1;
          if (!is_hex) begin
            next_r.st = ST_IDLE;
          end else if (r.dig == 4'h1) begin
            next_r.dig = 4'h0;
            next_r.len = hex_val[5:0];
            // Length outside 1..32 drops the command
            next_r.st = (hex_val >= STR_LEN_MIN && hex_val <= STR_LEN_MAX) ? ST_SADDR : ST_IDLE;
          end
        end
      end
      ST_SADDR: begin
        if (RX_VALID) begin
          next_r.acc = {r.acc[27:0], nib};
          next_r.dig = r.dig + 4'h1;
          if (!is_hex) begin
            next_r.st = ST_IDLE;
          end else if (r.dig == 4'h1) begin
            next_r.sel_addr = hex_val[6:0];
            next_r.units = 7'h00;
            next_r.pos = 5'h00;
            next_r.st = ({4'h0, hex_val} <= ADDR_MAX) ? ST_SDATA : ST_IDLE;
          end
        end
      end
      ST_SDATA: begin
        if (RX_VALID) begin
          if (unit_sum <= {1'b0, r.len}) begin
            str_we = 1'b1;
            str_widx = {r.sel_addr, r.pos};
            str_wdata = RX_DATA;
            next_r.pos = r.pos + 5'h01;
            next_r.units = unit_sum;
          end
          // Declared length reached: later bytes fall into idle and vanish
          if (unit_sum >= {1'b0, r.len}) begin
            len_we = 1'b1;
            len_widx = r.sel_addr;
            len_wdata = (unit_sum <= {1'b0, r.len}) ? 6'({1'b0, r.pos} + 6'h01) : {1'b0, r.pos};
            next_r.st = ST_IDLE;
          end
        end
      end
      ST_NADDR: begin
        if (RX_VALID) begin
          next_r.acc = {r.acc[27:0], nib};
          next_r.dig = r.dig + 4'h1;
          if (!is_hex) begin
            next_r.st = ST_IDLE;
          end else if (r.dig == 4'h2) begin
            next_r.dig = 4'h0;
            next_r.sel_addr = hex_acc[6:0];
            next_r.st = (hex_acc <= ADDR_MAX) ? ST_NDATA : ST_IDLE;
          end
        end
      end
      ST_NDATA: begin
        if (RX_VALID) begin
          next_r.acc = num_val;
          next_r.dig = r.dig + 4'h1;
          if (!is_hex) begin
            next_r.st = ST_IDLE;
          end else if (r.dig == (r.wide ? 4'h7 : 4'h3)) begin
            host_num_we = 1'b1;
            next_r.st = ST_IDLE;
            // Sign nibble F is kept raw; low seven digits carry magnitude
            if (r.wide) begin
              num_wdata = num_val;
            end else begin
              num_wdata = {num_mem[r.sel_addr][31:16], num_val[15:0]};
            end
          end
        end
      end
      ST_CTYPE: begin
        if (RX_VALID) begin
          next_r.dig = 4'h0;
          next_r.acc = 32'h0000_0000;
          next_r.ctype = (RX_DATA == TYPE_NUM);
          next_r.st = (RX_DATA == TYPE_STR || RX_DATA == TYPE_NUM) ? ST_CSRC : ST_IDLE;
        end
      end
      ST_CSRC, ST_CDST: begin
        if (RX_VALID) begin
          next_r.acc = {20'h00000, dec_acc};
          next_r.dig = r.dig + 4'h1;
          if (!is_dec) begin
            next_r.st = ST_IDLE;
          end else if (r.dig == 4'h2) begin
            next_r.dig = 4'h0;
            next_r.acc = 32'h0000_0000;
            next_r.pos = 5'h00;
            if (dec_acc > ADDR_MAX) begin
              next_r.st = ST_IDLE;
            end else if (r.st == ST_CSRC) begin
              next_r.src = dec_acc[6:0];
              next_r.st = ST_CDST;
            end else begin
              next_r.sel_addr = dec_acc[6:0];
              next_r.st = ST_COPY;
            end
          end
        end
      end
      ST_COPY: begin
        if (r.ctype) begin
          host_num_we = 1'b1;
          num_wdata = num_mem[r.src];
          next_r.st = ST_IDLE;
        end else begin
          // One byte a cycle; bytes arriving meanwhile are not looked at
          str_we = 1'b1;
          str_widx = {r.sel_addr, r.pos};
          str_wdata = str_mem[{r.src, r.pos}];
          next_r.pos = r.pos + 5'h01;
          if (r.pos == 5'h1F) begin
            len_we = 1'b1;
            len_widx = r.sel_addr;
            len_wdata = len_mem[r.src];
            next_r.st = ST_IDLE;
          end
        end
      end
      default: next_r.st = ST_IDLE;
    endcase

    // Byte gap watchdog while a command is half received
    if (r.st == ST_IDLE || r.st == ST_COPY || next_r.st == ST_IDLE || RX_VALID) begin
      next_r.gap = 13'h0000;
    end else if (tick) begin
      next_r.gap = r.gap + 13'h0001;
      if (r.gap + 13'h0001 >= GAP_TICKS) begin
        next_r.st = ST_IDLE;
        next_r.err = 1'b1;
      end
    end

    num_widx = r.sel_addr;
    num_we = host_num_we;

    // Local numeral entry: write table when the host is not, then notify
    if (NUM_SET_VALID && !r.np_valid) begin
      next_r.np_valid = 1'b1;
      next_r.np_done = 1'b0;
      next_r.np = NUM_SET;
    end else if (r.np_valid && !r.np_done && !host_num_we) begin
      num_we = 1'b1;
      num_widx = r.np.addr;
      num_wdata = r.np.wide ? r.np.value : {num_mem[r.np.addr][31:16], r.np.value[15:0]};
      next_r.np_done = 1'b1;
    end

    // Touch switches
    next_r.bit_mode = BIT_MODE;
    held = 64'h0;
    if (r.bit_mode != BIT_MODE) begin
      // Screen change: drop old mode's lighting and history
      next_r.light = 64'h0;
      next_r.light_cnt = 8'h00;
      next_r.sw_prev = 64'h0;
    end else if (r.bit_mode) begin
      next_r.light = eff;
      next_r.sw_prev = eff;
      if (eff != r.sw_prev) begin
        next_r.sw_pend = 1'b1;
        next_r.sw_code = CODE_SW_BIT;
        next_r.sw_val = eff;
        next_r.sw_nib = NIB_SW_BIT;
      end
    end else begin
      next_r.sw_prev = r.sw_s2;
      for (int i = 0; i < NUM_SW; i++) begin
        if (r.sw_s2[i]) begin
          press_idx = 6'(i);
        end
      end
      held = r.sw_s2 & (r.sw_s2 - 64'h1);
      // Only a lone press from all-released counts; a crowd is ignored
      if (r.sw_s2 != 64'h0 && r.sw_prev == 64'h0 && held == 64'h0) begin
        next_r.sw_pend = 1'b1;
        next_r.sw_code = CODE_SW_NUM;
        next_r.sw_val = {24'h000000, 2'b00, press_idx, 32'h0000_0000};
        next_r.sw_nib = NIB_SW_NUM;
        next_r.light = 64'h1 << press_idx;
        next_r.light_cnt = LIGHT_TICKS;
      end else if (r.light_cnt != 8'h00 && tick) begin
        next_r.light_cnt = r.light_cnt - 8'h01;
        if (r.light_cnt == 8'h01) begin
          next_r.light = 64'h0;
        end
      end
    end

    // Transmit: one byte per accepted handshake
    if (!r.tx_valid || TX_READY) begin
      next_r.tx_valid = 1'b0;
      if (r.tx_busy) begin
        next_r.tx_valid = 1'b1;
        next_r.tx_pos = r.tx_pos + 5'h01;
        if (r.tx_pos == 5'h00) begin
          next_r.tx_data = ESC_CHAR;
        end else if (r.tx_pos == 5'h01) begin
          next_r.tx_data = r.tx_code;
        end else if (r.tx_pos < 5'(r.tx_nib + 5'h02)) begin
          next_r.tx_data = to_ascii(r.tx_val[63:60]);
          next_r.tx_val = {r.tx_val[59:0], 4'h0};
        end else begin
          next_r.tx_data = CR_CHAR;
          next_r.tx_busy = 1'b0;
        end
      end
    end
    if (!r.tx_busy) begin
      next_r.tx_pos = 5'h00;
      if (r.np_valid && r.np_done) begin
        next_r.tx_busy = 1'b1;
        next_r.np_valid = 1'b0;
        next_r.tx_code = r.np.wide ? CODE_NOTE8 : CODE_NOTE4;
        next_r.tx_nib = r.np.wide ? NIB_NOTE8 : NIB_NOTE4;
        next_r.tx_val = r.np.wide ? {5'h00, r.np.addr, r.np.value, 20'h00000}
                                  : {5'h00, r.np.addr, r.np.value[15:0], 36'h0};
      end else if (r.sw_pend) begin
        next_r.tx_busy = 1'b1;
        next_r.sw_pend = next_r.sw_pend && (next_r.sw_val != r.sw_val);
        next_r.tx_code = r.sw_code;
        next_r.tx_nib = r.sw_nib;
        next_r.tx_val = r.sw_val;
      end
    end
    // Ready output kept in its own flop
    next_r.np_free = !next_r.np_valid;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.np_free <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Tables carry no reset; contents are undefined until written
  always_ff @(posedge CLOCK) begin
    if (str_we) begin
      str_mem[str_widx] <= str_wdata;
    end
    if (len_we) begin
      len_mem[len_widx] <= len_wdata;
    end
    if (num_we) begin
      num_mem[num_widx] <= num_wdata;
    end
  end

  assign TX_VALID = r.tx_valid;
  assign TX_DATA = r.tx_data;
  assign NUM_SET_READY = r.np_free;
  assign SW_LIGHT = r.light;
  assign TIMEOUT_ERR = r.err;
endmodule : mts_top
`default_nettype wire

// File: dv/mts_host.sv
// Host partner: byte sender and notification receiver with optional stall
`timescale 1ns/100ps
`default_nettype none
module mts_host (
  input wire logic clock,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic [7:0] got_q[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // Slow host accepts only every other cycle
  always @(negedge clock) tx_ready <= slow ? !tx_ready : 1'b1;
  always @(posedge clock) if (tx_valid && tx_ready) got_q.push_back(tx_data);
  task automatic send_byte(input logic [7:0] b);
    @(negedge clock);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge clock);
    rx_valid = 1'b0;
    // Released line must not keep showing the old byte
    rx_data = ~b;
  endtask : send_byte
endmodule : mts_host
`default_nettype wire

// File: dv/mts_sva.sv
// Port checker for the command block, bound to the top module
`timescale 1ns/100ps
`default_nettype none
module mts_sva import mts_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic RX_VALID,
  input wire logic TX_READY,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic [63:0] SW_PRESS,
  input wire logic BIT_MODE,
  input wire logic [63:0] SW_LIGHT,
  input wire logic TIMEOUT_ERR
);
  // One tick of slack for the free running divider phase
  localparam int LIGHT_MAX = (int'(LIGHT_TICKS) + 1) * TICK_CYCLES + 8;
  localparam int GAP_MIN = (int'(GAP_TICKS) - 1) * TICK_CYCLES;
  logic [31:0] lit_cnt;
  logic [31:0] idle_cnt;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      lit_cnt <= '0;
      idle_cnt <= '0;
    end else begin
      lit_cnt <= (!BIT_MODE && SW_LIGHT != '0 && $stable(SW_LIGHT)) ? lit_cnt + 1 : '0;
      idle_cnt <= RX_VALID ? '0 : idle_cnt + 1;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  reset_vals_a: assert property ($rose(NRST) |-> !TX_VALID && TX_DATA == 8'h00 && SW_LIGHT == '0)
    else $error("outputs not quiet after reset");
  tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("tx byte changed before acceptance");
  frame_start_a: assert property ($rose(TX_VALID) |-> TX_DATA == ESC_CHAR)
    else $error("frame does not open with escape");
  frame_end_a: assert property (TX_VALID && TX_READY && TX_DATA == CR_CHAR |=>
    !TX_VALID || TX_DATA == ESC_CHAR)
    else $error("tx valid held after frame end");
  light_lim_a: assert property (lit_cnt <= LIGHT_MAX)
    else $error("number mode light too long");
  num_single_a: assert property ((!BIT_MODE) [*4] |-> $countones(SW_LIGHT) <= 1)
    else $error("several lights in number mode");
  bit_held_a: assert property ((BIT_MODE && $stable(SW_PRESS)) [*6] |->
    (SW_LIGHT & SW_PRESS) == SW_PRESS) else $error("held switch not lit");
  bit_clear_a: assert property ((BIT_MODE && SW_PRESS == '0) [*6] |-> SW_LIGHT == '0)
    else $error("light stays after release");
  timeout_gap_a: assert property ($rose(TIMEOUT_ERR) |-> idle_cnt >= GAP_MIN)
    else $error("timeout raised too early");
  cover property ($rose(TIMEOUT_ERR));
  cover property (TX_VALID && TX_READY && TX_DATA == CODE_SW_BIT);
  cover property (!BIT_MODE && $rose(SW_LIGHT != '0));
endmodule : mts_sva
bind mts_top mts_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_u (.CLOCK(CLOCK), .NRST(NRST),
  .RX_VALID(RX_VALID), .TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
  .SW_PRESS(SW_PRESS), .BIT_MODE(BIT_MODE), .SW_LIGHT(SW_LIGHT), .TIMEOUT_ERR(TIMEOUT_ERR));
`default_nettype wire

// File: dv/mts_top_bench.sv
// Self-checking bench for the command block
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module mts_top_bench import mts_pkg::*;;
  localparam int TICKS = 2;
  localparam int GAP_CY = int'(GAP_TICKS) * TICKS;
  localparam int LIGHT_CY = int'(LIGHT_TICKS) * TICKS;
  logic clock, nrst, rx_valid, tx_ready, tx_valid, bit_mode, ns_valid, ns_ready, t_err, slow;
  logic [7:0] rx_data, tx_data;
  logic [63:0] sw_press, sw_light;
  mts_numset_type num_set;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  mts_top #(.TICK_CYCLES(TICKS)) dut_u (.CLOCK(clock), .NRST(nrst), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .TX_READY(tx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .SW_PRESS(sw_press), .BIT_MODE(bit_mode), .NUM_SET_VALID(ns_valid), .NUM_SET(num_set),
    .NUM_SET_READY(ns_ready), .SW_LIGHT(sw_light), .TIMEOUT_ERR(t_err));
  mts_host host_u (.clock(clock), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic cmd(input string s);
    host_u.send_byte(ESC_CHAR);
    foreach (s[i]) host_u.send_byte(s[i]);
  endtask : cmd
  task automatic make_frame(input logic [7:0] code, input logic [63:0] val, input int n);
    logic [3:0] nib;
    exp_q = {ESC_CHAR, code};
    for (int i = n - 1; i >= 0; i--) begin
      nib = val[4*i +: 4];
      exp_q.push_back(nib < 4'hA ? 8'h30 + nib : 8'h37 + nib);
    end
    exp_q.push_back(CR_CHAR);
  endtask : make_frame
  task automatic check_frame(input string what);
    int i;
    i = 0;
    while (host_u.got_q.size() < exp_q.size() && i < 200) begin
      @(posedge clock);
      i++;
    end
    repeat (3) @(negedge clock);
    `CHECK(what, exp_q.size(), host_u.got_q.size())
    foreach (exp_q[k]) if (k < host_u.got_q.size()) `CHECK(what, exp_q[k], host_u.got_q[k])
    host_u.got_q.delete();
  endtask : check_frame
  task automatic num_req(input logic [6:0] a, input logic [31:0] v, input logic w);
    int i;
    i = 0;
    @(negedge clock);
    while (ns_ready !== 1'b1 && i < 100) begin
      @(negedge clock);
      i++;
    end
    ns_valid = 1'b1;
    num_set = '{addr: a, value: v, wide: w};
    @(negedge clock);
    ns_valid = 1'b0;
  endtask : num_req
  task automatic t_numset;
    num_req(7'h05, 32'h0000_1234, 1'b0);
    make_frame(CODE_NOTE4, {40'h0, 12'h005, 16'h1234}, 7);
    check_frame("note4 frame");
    slow = 1'b1;
    num_req(7'h7F, 32'hF000_0123, 1'b1);
    make_frame(CODE_NOTE8, {20'h0, 12'h07F, 32'hF000_0123}, 11);
    check_frame("note8 frame, stalled host");
    slow = 1'b0;
  endtask : t_numset
  task automatic t_sw_num;
    sw_press[13] = 1'b1;
    make_frame(CODE_SW_NUM, 64'h0D, 8);
    check_frame("switch number frame");
    repeat (LIGHT_CY - 100) @(negedge clock);
    `CHECK("lit while held", 1'b1, sw_light[13])
    sw_press[20] = 1'b1;
    repeat (150) @(negedge clock);
    `CHECK("dark after hold time", 64'h0, sw_light)
    `CHECK("second press silent", 0, host_u.got_q.size())
    sw_press = '0;
    repeat (5) @(negedge clock);
  endtask : t_sw_num
  task automatic t_sw_bit;
    bit_mode = 1'b1;
    repeat (5) @(negedge clock);
    // Rows 0 and 1 share column 0, so switch 9 reads as pressed
    sw_press = 64'h103;
    make_frame(CODE_SW_BIT, 64'h303, 16);
    check_frame("ghosted bit map");
    `CHECK("held lights", 64'h303, sw_light)
    sw_press = '0;
    make_frame(CODE_SW_BIT, 64'h0, 16);
    check_frame("release map");
    `CHECK("released lights", 64'h0, sw_light)
    bit_mode = 1'b0;
  endtask : t_sw_bit
  task automatic t_timeout;
    cmd("B0305A");
    repeat (GAP_CY - 1000) @(negedge clock);
    `CHECK("no early timeout", 1'b0, t_err)
    repeat (1100) @(negedge clock);
    `CHECK("short string timeout", 1'b1, t_err)
    cmd("Z");
    repeat (3) @(negedge clock);
    `CHECK("error cleared", 1'b0, t_err)
  endtask : t_timeout
  task automatic t_no_timeout;
    // Any command left half taken would raise a timeout at the end
    cmd("B0105QB");
    `CHECK("string byte", 8'h51, dut_u.str_mem[12'h0A0])
    `CHECK("string length", 6'h01, dut_u.len_mem[7'h05])
    cmd("B0206");
    host_u.send_byte(MARK_MIN);
    `CHECK("mark byte", 8'h80, dut_u.str_mem[12'h0C0])
    `CHECK("mark length", 6'h01, dut_u.len_mem[7'h06])
    cmd("B2105XY");
    cmd("B0005");
    cmd("B0180A");
    cmd("D07FF7654321");
    `CHECK("eight digit write", 32'hF765_4321, dut_u.num_mem[7'h7F])
    cmd("C07F1234");
    `CHECK("four digit write", 32'hF765_1234, dut_u.num_mem[7'h7F])
    cmd("/1005006");
    @(negedge clock);
    `CHECK("numeral copy", 16'h1234, dut_u.num_mem[7'h06][15:0])
    cmd("/0005006");
    repeat (33) @(negedge clock);
    `CHECK("string copy", 8'h51, dut_u.str_mem[12'h0C0])
    cmd("/2005006");
    cmd("/1128006");
    repeat (GAP_CY + 100) @(negedge clock);
    `CHECK("no stray timeout", 1'b0, t_err)
  endtask : t_no_timeout
  initial begin
    nrst = 1'b0;
    slow = 1'b0;
    bit_mode = 1'b0;
    ns_valid = 1'b0;
    num_set = '0;
    sw_press = '0;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    `CHECK("reset outputs", {1'b0, 8'h00, 1'b1, 64'h0, 1'b0},
      {tx_valid, tx_data, ns_ready, sw_light, t_err})
    t_numset();
    t_sw_num();
    t_sw_bit();
    t_timeout();
    t_no_timeout();
    finish_test();
  end
endmodule : mts_top_bench
`default_nettype wire
